// ### logic/cgc_pkg.sv
// Constants for the codec gain-control register bank.
// Assumes a 100 MHz pclk and APB byte addressing with one word per register.
package cgc_pkg;

  // ****************************************
  // Register map (index, byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_ADC_GAIN = 8'h01;
  localparam logic [7:0] IDX_DAC_VOL = 8'h02;
  localparam logic [7:0] IDX_AUDIO_CTRL2 = 8'h04;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_ADC_GAIN = {2'h0, IDX_ADC_GAIN, 2'h0};
  localparam logic [11:0] ADDR_DAC_VOL = {2'h0, IDX_DAC_VOL, 2'h0};
  localparam logic [11:0] ADDR_AUDIO_CTRL2 = {2'h0, IDX_AUDIO_CTRL2, 2'h0};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ADC_MUTE_BIT = 15;
  localparam int ADC_GAIN_LSB = 8;
  localparam int ADC_TARGET_LSB = 5;
  localparam int ADC_TC_LSB = 1;
  localparam int ADC_AGC_EN_BIT = 0;
  localparam int DAC_LMUTE_BIT = 15;
  localparam int DAC_LVOL_LSB = 8;
  localparam int DAC_RMUTE_BIT = 7;
  localparam int DAC_RVOL_LSB = 0;
  localparam int CTRL2_SOFT_STEP_BIT = 11;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic REC_MUTE_RST = 1'b1;
  localparam logic [6:0] REC_GAIN_RST = 7'h00;
  localparam logic [2:0] TARGET_RST = 3'h0;
  localparam logic [3:0] TC_RST = 4'h0;
  localparam logic AGC_EN_RST = 1'b0;
  localparam logic PLAY_MUTE_RST = 1'b1;
  localparam logic [6:0] PLAY_VOL_RST = 7'h7F;
  localparam logic SOFT_STEP_RST = 1'b0;

  // ****************************************
  // Gain limits, half-dB units, signed
  // ****************************************
  localparam logic [6:0] PGA_CODE_MAX = 7'h77;
  localparam logic [7:0] GAIN_MAX = 8'h77;
  localparam logic [7:0] GAIN_MIN = 8'hE8;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 100000000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
  localparam int MS_CNT_W = 9;
  localparam int TICK_CNT_W = 17;

  typedef enum logic [0:0] {
    CGC_STEP_FIRST = 1'b0,
    CGC_STEP_SECOND = 1'b1
  } cgc_step_t;

endpackage

// ### logic/cgc_gain_stepper.sv
// Soft-stepping of the applied record gain toward a requested gain.
// Assumes word_strobe is a one-cycle pulse on pclk, once per record word.
`timescale 1ns/1ps
module cgc_gain_stepper (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] target,
  input wire logic word_strobe,
  input wire logic two_period,
  output logic [7:0] gain_reg
);

  cgc_pkg::cgc_step_t phase_reg;
  logic step_now;

  // Step on every strobe, or on every second one
  assign step_now = word_strobe & (~two_period | (phase_reg == cgc_pkg::CGC_STEP_SECOND));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= cgc_pkg::CGC_STEP_FIRST;
    end else if (word_strobe) begin
      case (phase_reg)
        cgc_pkg::CGC_STEP_FIRST: begin
          phase_reg <= two_period ? cgc_pkg::CGC_STEP_SECOND : cgc_pkg::CGC_STEP_FIRST;
        end
        cgc_pkg::CGC_STEP_SECOND: begin
          phase_reg <= cgc_pkg::CGC_STEP_FIRST;
        end
        default: begin
          phase_reg <= cgc_pkg::CGC_STEP_FIRST;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_reg <= 8'h00;
    end else if (step_now) begin
      if ($signed(gain_reg) < $signed(target)) begin
        gain_reg <= gain_reg + 8'h01;
      end else if ($signed(gain_reg) > $signed(target)) begin
        gain_reg <= gain_reg - 8'h01;
      end
    end
  end

endmodule

// ### logic/cgc_regs.sv
// Gain-control register bank of the audio codec, reached over APB.
// Assumes rec_word_strobe and rec_level_hdb come from logic on pclk.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module cgc_regs #(
  parameter int TICK_CYCLES = cgc_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rec_word_strobe,
  input wire logic [7:0] rec_level_hdb,
  output logic rec_channel_mute,
  output logic [7:0] rec_applied_gain,
  output logic [7:0] auto_gain_target_level,
  output logic auto_gain_enable,
  output logic play_left_mute,
  output logic [6:0] play_left_volume,
  output logic play_right_mute,
  output logic [6:0] play_right_volume
);

  // ****************************************
  // Decode functions
  // ****************************************
  function automatic logic [7:0] target_hdb(input logic [2:0] code);
    case (code)
      3'h0: target_hdb = 8'hF5;
      3'h1: target_hdb = 8'hF0;
      3'h2: target_hdb = 8'hEC;
      3'h3: target_hdb = 8'hE8;
      3'h4: target_hdb = 8'hE4;
      3'h5: target_hdb = 8'hDE;
      3'h6: target_hdb = 8'hD8;
      default: target_hdb = 8'hD0;
    endcase
  endfunction

  function automatic logic [8:0] attack_ms(input logic [1:0] code);
    case (code)
      2'h0: attack_ms = 9'h008;
      2'h1: attack_ms = 9'h00B;
      2'h2: attack_ms = 9'h010;
      default: attack_ms = 9'h014;
    endcase
  endfunction

  function automatic logic [8:0] decay_ms(input logic [1:0] code);
    case (code)
      2'h0: decay_ms = 9'h064;
      2'h1: decay_ms = 9'h0C8;
      2'h2: decay_ms = 9'h190;
      default: decay_ms = 9'h1F4;
    endcase
  endfunction

  function automatic logic [7:0] pga_gain(input logic [6:0] code);
    pga_gain = (code > cgc_pkg::PGA_CODE_MAX) ? {1'b0, cgc_pkg::PGA_CODE_MAX} : {1'b0, code};
  endfunction

  function automatic logic hdb_gt(input logic [7:0] a, input logic [7:0] b);
    hdb_gt = $signed(a) > $signed(b);
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  localparam int TICK_CNT_W_L = cgc_pkg::TICK_CNT_W;
  localparam logic [TICK_CNT_W_L-1:0] TICK_LAST = TICK_CNT_W_L'(TICK_CYCLES - 1);

  logic rec_mute_reg;
  logic [6:0] rec_gain_code_reg;
  logic [2:0] auto_gain_target_reg;
  logic [3:0] auto_gain_time_const_reg;
  logic auto_gain_enable_reg;
  logic play_left_mute_reg;
  logic [6:0] play_left_volume_reg;
  logic play_right_mute_reg;
  logic [6:0] play_right_volume_reg;
  logic rec_gain_soft_step_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [7:0] target_level_reg;
  logic [7:0] agc_gain_reg;
  logic [7:0] applied_gain;
  logic [7:0] step_target;
  logic [TICK_CNT_W_L-1:0] tick_cnt_reg;
  logic ms_tick;
  logic [8:0] attack_cnt_reg;
  logic [8:0] decay_cnt_reg;
  logic attack_due;
  logic decay_due;
  logic setup_phase;
  logic wr_en;
  logic addr_hit;
  logic [31:0] rd_value;
  logic wr_adc;
  logic wr_dac;
  logic wr_ctrl2;
  logic [8:0] attack_limit;
  logic [8:0] decay_limit;
  logic agc_cut;
  logic agc_boost;

  // ****************************************
  // APB slave
  // ****************************************
  assign setup_phase = psel & ~penable;
  assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign addr_hit = (paddr == cgc_pkg::ADDR_ADC_GAIN) || (paddr == cgc_pkg::ADDR_DAC_VOL) ||
                    (paddr == cgc_pkg::ADDR_AUDIO_CTRL2);

  // ****************************************
  // Write enables
  // ****************************************
  // Unmapped addresses raise no enable, so they change nothing
  assign wr_adc = wr_en && (paddr == cgc_pkg::ADDR_ADC_GAIN);
  assign wr_dac = wr_en && (paddr == cgc_pkg::ADDR_DAC_VOL);
  assign wr_ctrl2 = wr_en && (paddr == cgc_pkg::ADDR_AUDIO_CTRL2);

  always_comb begin
    rd_value = 32'h0000_0000;
    case (paddr)
      cgc_pkg::ADDR_ADC_GAIN: begin
        if (auto_gain_enable_reg) begin
          rd_value[15:8] = applied_gain;
        end else begin
          rd_value[15:8] = {rec_mute_reg, rec_gain_code_reg};
        end
        rd_value[7:5] = auto_gain_target_reg;
        rd_value[4:1] = auto_gain_time_const_reg;
        rd_value[0] = auto_gain_enable_reg;
      end
      cgc_pkg::ADDR_DAC_VOL: begin
        rd_value[15:0] = {play_left_mute_reg, play_left_volume_reg,
                          play_right_mute_reg, play_right_volume_reg};
      end
      cgc_pkg::ADDR_AUDIO_CTRL2: begin
        rd_value[cgc_pkg::CTRL2_SOFT_STEP_BIT] = rec_gain_soft_step_reg;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // Answer is prepared in the setup cycle so the access phase lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~addr_hit;
      if (setup_phase) begin
        prdata_reg <= (addr_hit && !pwrite) ? rd_value : 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Record gain register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_mute_reg <= cgc_pkg::REC_MUTE_RST;
      rec_gain_code_reg <= cgc_pkg::REC_GAIN_RST;
      auto_gain_target_reg <= cgc_pkg::TARGET_RST;
      auto_gain_time_const_reg <= cgc_pkg::TC_RST;
      auto_gain_enable_reg <= cgc_pkg::AGC_EN_RST;
    end else if (wr_adc) begin
      if (pstrb[1]) begin
        rec_mute_reg <= pwdata[cgc_pkg::ADC_MUTE_BIT];
        rec_gain_code_reg <= pwdata[cgc_pkg::ADC_GAIN_LSB +: 7];
      end
      if (pstrb[0]) begin
        auto_gain_target_reg <= pwdata[cgc_pkg::ADC_TARGET_LSB +: 3];
        auto_gain_time_const_reg <= pwdata[cgc_pkg::ADC_TC_LSB +: 4];
        auto_gain_enable_reg <= pwdata[cgc_pkg::ADC_AGC_EN_BIT];
      end
    end
  end

  // ****************************************
  // Playback volume register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      play_left_mute_reg <= cgc_pkg::PLAY_MUTE_RST;
      play_left_volume_reg <= cgc_pkg::PLAY_VOL_RST;
      play_right_mute_reg <= cgc_pkg::PLAY_MUTE_RST;
      play_right_volume_reg <= cgc_pkg::PLAY_VOL_RST;
    end else if (wr_dac) begin
      if (pstrb[1]) begin
        play_left_mute_reg <= pwdata[cgc_pkg::DAC_LMUTE_BIT];
        play_left_volume_reg <= pwdata[cgc_pkg::DAC_LVOL_LSB +: 7];
      end
      if (pstrb[0]) begin
        play_right_mute_reg <= pwdata[cgc_pkg::DAC_RMUTE_BIT];
        play_right_volume_reg <= pwdata[cgc_pkg::DAC_RVOL_LSB +: 7];
      end
    end
  end

  // ****************************************
  // Soft-step control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_gain_soft_step_reg <= cgc_pkg::SOFT_STEP_RST;
    end else if (wr_ctrl2 && pstrb[1]) begin
      rec_gain_soft_step_reg <= pwdata[cgc_pkg::CTRL2_SOFT_STEP_BIT];
    end
  end

  // ****************************************
  // Millisecond timebase for AGC
  // ****************************************
  // Derived from pclk so the time constants do not follow the sample rate
  assign ms_tick = (tick_cnt_reg == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (ms_tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_CNT_W_L'(1);
    end
  end

  assign attack_limit = attack_ms(auto_gain_time_const_reg[1:0]) - 9'h001;
  assign decay_limit = decay_ms(auto_gain_time_const_reg[3:2]) - 9'h001;
  assign attack_due = ms_tick && (attack_cnt_reg >= attack_limit);
  assign decay_due = ms_tick && (decay_cnt_reg >= decay_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attack_cnt_reg <= 9'h000;
    end else if (!auto_gain_enable_reg || attack_due) begin
      attack_cnt_reg <= 9'h000;
    end else if (ms_tick) begin
      attack_cnt_reg <= attack_cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decay_cnt_reg <= 9'h000;
    end else if (!auto_gain_enable_reg || decay_due) begin
      decay_cnt_reg <= 9'h000;
    end else if (ms_tick) begin
      decay_cnt_reg <= decay_cnt_reg + 9'h001;
    end
  end

  // ****************************************
  // AGC loop
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_level_reg <= 8'hF5;
    end else begin
      target_level_reg <= target_hdb(auto_gain_target_reg);
    end
  end

  // ****************************************
  // AGC decisions
  // ****************************************
  // Attack cuts when the level is above target, decay boosts when below
  assign agc_cut = attack_due && hdb_gt(rec_level_hdb, target_level_reg) &&
                   hdb_gt(agc_gain_reg, cgc_pkg::GAIN_MIN);
  assign agc_boost = decay_due && hdb_gt(target_level_reg, rec_level_hdb) &&
                     hdb_gt(cgc_pkg::GAIN_MAX, agc_gain_reg);

  // Loop starts from the gain in use when it is switched on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agc_gain_reg <= 8'h00;
    end else if (!auto_gain_enable_reg) begin
      agc_gain_reg <= applied_gain;
    end else if (agc_cut) begin
      agc_gain_reg <= agc_gain_reg - 8'h01;
    end else if (agc_boost) begin
      agc_gain_reg <= agc_gain_reg + 8'h01;
    end
  end

  // ****************************************
  // Applied record gain
  // ****************************************
  assign step_target = auto_gain_enable_reg ? agc_gain_reg : pga_gain(rec_gain_code_reg);

  cgc_gain_stepper u_stepper (
    .pclk(pclk),
    .presetn(presetn),
    .target(step_target),
    .word_strobe(rec_word_strobe),
    .two_period(rec_gain_soft_step_reg),
    .gain_reg(applied_gain)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rec_channel_mute = rec_mute_reg;
  assign rec_applied_gain = applied_gain;
  assign auto_gain_target_level = target_level_reg;
  assign auto_gain_enable = auto_gain_enable_reg;
  assign play_left_mute = play_left_mute_reg;
  assign play_left_volume = play_left_volume_reg;
  assign play_right_mute = play_right_mute_reg;
  assign play_right_volume = play_right_volume_reg;

endmodule

// ### test/cgc_regs_assertions.sv
// Checker for the codec gain-control register bank.
// Sees only the cgc_regs ports; bound to it at the foot of this file.
`timescale 1ns/1ps
module cgc_regs_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rec_word_strobe,
  input wire logic rec_channel_mute,
  input wire logic [7:0] rec_applied_gain,
  input wire logic [7:0] auto_gain_target_level,
  input wire logic auto_gain_enable,
  input wire logic play_left_mute,
  input wire logic [6:0] play_left_volume,
  input wire logic play_right_mute,
  input wire logic [6:0] play_right_volume
);
  // ****************************************
  // Helper terms
  // ****************************************
  localparam logic [7:0] TL [8] = '{8'hF5, 8'hF0, 8'hEC, 8'hE8, 8'hE4, 8'hDE, 8'hD8, 8'hD0};
  logic wr_ok;
  logic adc_wr;
  logic dac_wr;
  assign wr_ok = psel && penable && pready && pwrite;
  assign adc_wr = wr_ok && paddr == cgc_pkg::ADDR_ADC_GAIN;
  assign dac_wr = wr_ok && paddr == cgc_pkg::ADDR_DAC_VOL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************
  // Properties
  // ****************************************
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rec_mute_wr: assert property (
    adc_wr && pstrb[1] |=> rec_channel_mute == $past(pwdata[15]))
    else $error("record mute not taken from write");
  a_agc_en_wr: assert property (
    adc_wr && pstrb[0] |=> auto_gain_enable == $past(pwdata[0]))
    else $error("auto gain enable not taken from write");
  a_target_map: assert property (
    adc_wr && pstrb[0] |=> ##1 auto_gain_target_level == TL[$past(pwdata[7:5], 2)])
    else $error("target level decode wrong");
  a_left_play_wr: assert property (
    dac_wr && pstrb[1] |=> {play_left_mute, play_left_volume} == $past(pwdata[15:8]))
    else $error("left playback controls not taken from write");
  a_right_play_wr: assert property (
    dac_wr && pstrb[0] |=> {play_right_mute, play_right_volume} == $past(pwdata[7:0]))
    else $error("right playback controls not taken from write");
  a_gain_step: assert property (
    $changed(rec_applied_gain) |-> $past(rec_word_strobe)
      && (rec_applied_gain - $past(rec_applied_gain) == 8'h01
      || $past(rec_applied_gain) - rec_applied_gain == 8'h01))
    else $error("applied gain moved off a word strobe or by more than one step");
  a_gain_range: assert property (
    !(rec_applied_gain inside {[8'h78:8'hE7]}))
    else $error("applied gain outside its range");
  a_reset_vals: assert property (disable iff (1'b0)
    !presetn |-> play_left_mute && play_right_mute
      && play_left_volume == 7'h7F && play_right_volume == 7'h7F)
    else $error("playback controls not at reset values");
  c_adc_wr: cover property (adc_wr);
  c_dac_wr: cover property (dac_wr);
  c_agc_step: cover property (auto_gain_enable && $changed(rec_applied_gain));
endmodule

bind cgc_regs cgc_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .rec_word_strobe,
  .rec_channel_mute, .rec_applied_gain, .auto_gain_target_level, .auto_gain_enable,
  .play_left_mute, .play_left_volume, .play_right_mute, .play_right_volume);

// ### test/tb.sv
// Self-checking bench for the codec gain-control register bank.
// Drives APB and the record-word inputs itself; checker is bound separately.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam logic [11:0] A_ADC = cgc_pkg::ADDR_ADC_GAIN;
  localparam logic [11:0] A_DAC = cgc_pkg::ADDR_DAC_VOL;
  localparam logic [11:0] A_CT2 = cgc_pkg::ADDR_AUDIO_CTRL2;
  logic [7:0] tl [8] = '{8'hF5, 8'hF0, 8'hEC, 8'hE8, 8'hE4, 8'hDE, 8'hD8, 8'hD0};
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic rec_word_strobe = 1'b0;
  logic [7:0] rec_level_hdb = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rec_channel_mute;
  logic [7:0] rec_applied_gain;
  logic [7:0] auto_gain_target_level;
  logic auto_gain_enable;
  logic play_left_mute;
  logic [6:0] play_left_volume;
  logic play_right_mute;
  logic [6:0] play_right_volume;
  logic [31:0] rdata_q;
  logic err_q;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  cgc_regs #(.TICK_CYCLES(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .rec_word_strobe, .rec_level_hdb,
    .rec_channel_mute, .rec_applied_gain, .auto_gain_target_level, .auto_gain_enable,
    .play_left_mute, .play_left_volume, .play_right_mute, .play_right_volume);
  always #5 pclk = ~pclk;

  // ****************************************
  // Drivers
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic strobes(input int n);
    repeat (n) begin
      @(posedge pclk);
      rec_word_strobe <= 1'b1;
      @(posedge pclk);
      rec_word_strobe <= 1'b0;
    end
    @(posedge pclk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    apb(0, A_ADC, 0, 0);
    `CHK(rdata_q, 32'h0000_8000)
    apb(0, A_DAC, 0, 0);
    `CHK(rdata_q, 32'h0000_FFFF)
    `CHK({play_left_mute, play_left_volume, play_right_mute, play_right_volume}, 16'hFFFF)
    `CHK(rec_channel_mute, 1'b1)
    $display("done reset");
  endtask
  task automatic t_dac;
    apb(1, A_DAC, 32'h0000_2A55, 4'h3);
    `CHK({play_left_mute, play_left_volume}, 8'h2A)
    `CHK({play_right_mute, play_right_volume}, 8'h55)
    apb(1, A_DAC, 32'h0000_80FF, 4'h2);
    apb(1, 12'h00C, 32'h0000_0000, 4'hF);
    `CHK(err_q, 1'b1)
    apb(0, 12'h00C, 0, 0);
    `CHK({err_q, rdata_q}, 33'h1_0000_0000)
    apb(0, A_DAC, 0, 0);
    `CHK(rdata_q, 32'h0000_8055)
    $display("done dac");
  endtask
  task automatic t_fields;
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {16'h0, 8'h00, 3'(i), 4'(i * 5), 1'b0};
      apb(1, A_ADC, v, 4'h3);
      apb(0, A_ADC, 0, 0);
      `CHK(auto_gain_target_level, tl[i])
      `CHK(rdata_q, v)
    end
    `CHK(rec_channel_mute, 1'b0)
    $display("done fields");
  endtask
  task automatic t_step;
    apb(1, A_ADC, 32'h0000_0300, 4'h2);
    for (int i = 1; i <= 4; i++) begin
      strobes(1);
      `CHK(rec_applied_gain, 8'(i < 3 ? i : 3))
    end
    apb(1, A_ADC, 32'h0000_7F00, 4'h2);
    strobes(120);
    `CHK(rec_applied_gain, 8'h77)
    apb(1, A_CT2, 32'h0000_0800, 4'h2);
    apb(1, A_ADC, 32'h0000_7400, 4'h2);
    strobes(2);
    `CHK(rec_applied_gain, 8'h76)
    strobes(2);
    `CHK(rec_applied_gain, 8'h75)
    apb(1, A_CT2, 32'h0000_0000, 4'h2);
    $display("done step");
  endtask
  task automatic t_agc;
    apb(1, A_ADC, 32'h0000_0001, 4'h1);
    `CHK(auto_gain_enable, 1'b1)
    strobes(200);
    `CHK(rec_applied_gain inside {8'h70, 8'h71}, 1'b1)
    strobes(6000);
    `CHK(rec_applied_gain, 8'hE8)
    apb(0, A_ADC, 0, 0);
    `CHK(rdata_q, 32'h0000_E801)
    @(posedge pclk);
    rec_level_hdb <= 8'hC0;
    strobes(1250);
    `CHK(rec_applied_gain inside {8'hEA, 8'hEB}, 1'b1)
    apb(1, A_ADC, 32'h0000_0000, 4'h1);
    strobes(150);
    `CHK(rec_applied_gain, 8'h74)
    apb(0, A_ADC, 0, 0);
    `CHK(rdata_q, 32'h0000_7400)
    $display("done agc");
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_dac;
    t_fields;
    t_step;
    t_agc;
    tally_and_finish;
  end
endmodule
